// [core/timer16_map.vh]
// Overview of operation
// - all timer events share one gated request
// - events wake from wait, never halt
// - control-a bits 7..5 enable interrupt groups
// - control-a bit 4 forces level two
// - control-a bit 3 forces level one
// - level two on compare-2, pin-1 in pulse modes
// - control-a bit 1 picks capture-1 edge
// - compare-1 match copies level one to pin
// - control-b bit 7 gates only pin one
// - control-b bit 6 gates only pin two
// - single-pulse mode fires from capture-1 edge
// - pwm mode: compare-1 width, compare-2 period
// - control-b bits 3:2 select clock divider
// - no external pin: external select stops counter
// - control-b bit 1 picks capture-2 edge
// - control-b bit 0 picks external clock edge
// - capture-one flag: set, cleared via status+low
// - compare-one flag: match, cleared via status+low
// - overflow flag cleared via status+counter low only
// - capture-two and compare-two flags likewise
// - status read only, low bits zero
// - capture-1 loads whole 16-bit counter, FFFD in pulse mode
// - pulse and pwm both set: pwm wins
// - pwm compare-2 reloads counter with FFFC
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH

// register byte addresses
`define A_CTRL_A      8'h00
`define A_CTRL_B      8'h04
`define A_FLAGS       8'h08
`define A_CAP1_HI     8'h0C
`define A_CAP1_LO     8'h10
`define A_CMP1_HI     8'h14
`define A_CMP1_LO     8'h18
`define A_CMP2_HI     8'h1C
`define A_CMP2_LO     8'h20
`define A_CNT_HI      8'h24
`define A_CNT_LO      8'h28
`define A_ALT_HI      8'h2C
`define A_ALT_LO      8'h30
`define A_CAP2_HI     8'h34
`define A_CAP2_LO     8'h38

// control-a fields
`define CA_CAP_IE     7
`define CA_CMP_IE     6
`define CA_OVF_IE     5
`define CA_FORCE2     4
`define CA_FORCE1     3
`define CA_LVL2       2
`define CA_EDGE1      1
`define CA_LVL1       0
// control-b fields
`define CB_PIN1_EN    7
`define CB_PIN2_EN    6
`define CB_ONEPULSE   5
`define CB_PWM        4
`define CB_CLK_HI     3
`define CB_CLK_LO     2
`define CB_EDGE2      1
`define CB_EXT_EDGE   0
// flag positions
`define F_CAP1        7
`define F_CMP1        6
`define F_OVF         5
`define F_CAP2        4
`define F_CMP2        3

// clock select codes
`define CLK_DIV4      2'h0
`define CLK_DIV2      2'h1
`define CLK_DIV8      2'h2
`define CLK_EXT       2'h3

// reset and special values
`define CTRL_RST      8'h00
`define FLAGS_RST     8'h00
`define CNT_RST       16'hFFFC
`define CNT_TOP       16'hFFFF
`define CNT_OPM_CAP   16'hFFFD
`define CMP_RST       16'h8000
`define CAP_RST       16'h0000
`define FLAGS_MASK    8'hF8

`endif

// [core/timer16_control_status_irq.v]
`timescale 1ns/1ps
`include "timer16_map.vh"
module timer16_control_status_irq #(
   parameter HAS_EXT_CLK = 1
) (
   // clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // cpu side
   input  wire        cpu_irq_mask,
   input  wire        wait_mode,
   input  wire        halt_mode,
   output reg         timer_irq,
   output reg         wake_from_wait,
   // pins
   input  wire        capture_one_input_pin,
   input  wire        capture_two_input_pin,
   input  wire        external_clock_pin,
   output reg         compare_one_output_pin,
   output reg         compare_one_pin_enable,
   output reg         compare_two_output_pin,
   output reg         compare_two_pin_enable
);

   reg  [7:0]  ctrl_a_q;
   reg  [7:0]  ctrl_b_q;
   reg  [7:0]  flags_q;
   reg  [7:0]  armed_q;
   reg  [15:0] cnt_q;
   reg  [15:0] cap1_q;
   reg  [15:0] cap2_q;
   reg  [15:0] cmp1_q;
   reg  [15:0] cmp2_q;
   reg         cmp1_hold_q;
   reg         cmp2_hold_q;
   reg  [2:0]  presc_q;
   reg         cap1_prev_q;
   reg         cap2_prev_q;
   reg         ext_prev_q;
   reg         lvl1_q;
   reg         lvl2_q;

   // one-hot address decode; zero means unmapped
   function [14:0] decode;
      input [7:0] a;
      begin
         decode = 15'h0000;
         case (a)
            `A_CTRL_A:  decode[0]  = 1'b1;
            `A_CTRL_B:  decode[1]  = 1'b1;
            `A_FLAGS:   decode[2]  = 1'b1;
            `A_CAP1_HI: decode[3]  = 1'b1;
            `A_CAP1_LO: decode[4]  = 1'b1;
            `A_CMP1_HI: decode[5]  = 1'b1;
            `A_CMP1_LO: decode[6]  = 1'b1;
            `A_CMP2_HI: decode[7]  = 1'b1;
            `A_CMP2_LO: decode[8]  = 1'b1;
            `A_CNT_HI:  decode[9]  = 1'b1;
            `A_CNT_LO:  decode[10] = 1'b1;
            `A_ALT_HI:  decode[11] = 1'b1;
            `A_ALT_LO:  decode[12] = 1'b1;
            `A_CAP2_HI: decode[13] = 1'b1;
            `A_CAP2_LO: decode[14] = 1'b1;
            default:    decode     = 15'h0000;
         endcase
      end
   endfunction

   // edge match on a sampled pin: sel 1 rising, 0 falling
   function edge_hit;
      input now;
      input prev;
      input sel;
      begin
         edge_hit = sel ? (now & ~prev) : (~now & prev);
      end
   endfunction

   // terminal prescaler count for each clock code
   function [2:0] div_top;
      input [1:0] sel;
      begin
         case (sel)
            `CLK_DIV2: div_top = 3'h1;
            `CLK_DIV4: div_top = 3'h3;
            `CLK_DIV8: div_top = 3'h7;
            default:   div_top = 3'h0;
         endcase
      end
   endfunction

   wire [14:0] sel_dec  = decode(paddr);
   wire        mapped   = |sel_dec;
   wire        done     = psel & penable & pready;
   wire        wr_ok    = done & pwrite & mapped;
   wire        rd_ok    = done & ~pwrite & mapped;
   wire        acc_ok   = done & mapped;
   wire [7:0]  wbyte    = pwdata[7:0];

   wire        pwm_on   = ctrl_b_q[`CB_PWM];
   wire        opm_on   = ctrl_b_q[`CB_ONEPULSE] & ~pwm_on;
   wire [1:0]  clk_sel  = {ctrl_b_q[`CB_CLK_HI], ctrl_b_q[`CB_CLK_LO]};

   // timer tick
   wire        ext_edge = edge_hit(external_clock_pin, ext_prev_q,
                                   ctrl_b_q[`CB_EXT_EDGE]);
   wire        ext_tick = (HAS_EXT_CLK != 0) & ext_edge;
   wire        int_tick = (presc_q == div_top(clk_sel));
   wire        tick     = ~halt_mode &
                          ((clk_sel == `CLK_EXT) ? ext_tick : int_tick);

   // pin events
   wire        cap1_edge = edge_hit(capture_one_input_pin, cap1_prev_q,
                                    ctrl_a_q[`CA_EDGE1]);
   wire        cap2_edge = edge_hit(capture_two_input_pin, cap2_prev_q,
                                    ctrl_b_q[`CB_EDGE2]);
   // capture-1 pin is disconnected in pwm mode
   wire        cap1_ev   = cap1_edge & ~pwm_on & ~halt_mode;
   wire        cap2_ev   = cap2_edge & ~halt_mode;

   wire        cmp1_hit  = tick & ~cmp1_hold_q & (cnt_q == cmp1_q);
   wire        cmp2_hit  = tick & ~cmp2_hold_q & (cnt_q == cmp2_q);
   wire        ovf_hit   = tick & (cnt_q == `CNT_TOP);
   wire        cnt_wr    = wr_ok & (sel_dec[10] | sel_dec[12]);

   // flag set terms
   reg  [7:0]  set_v;
   reg  [7:0]  clr_v;
   always @* begin
      set_v = 8'h00;
      set_v[`F_CAP1] = cap1_ev | (pwm_on & cmp2_hit);
      set_v[`F_CMP1] = cmp1_hit & ~pwm_on & ~opm_on;
      set_v[`F_OVF]  = ovf_hit;
      set_v[`F_CAP2] = cap2_ev;
      set_v[`F_CMP2] = cmp2_hit & ~pwm_on;
      clr_v = 8'h00;
      // a low-byte access clears the flag only if status was read first
      clr_v[`F_CAP1] = acc_ok & sel_dec[4] & armed_q[`F_CAP1];
      clr_v[`F_CMP1] = acc_ok & sel_dec[6] & armed_q[`F_CMP1];
      clr_v[`F_OVF]  = acc_ok & sel_dec[10] & armed_q[`F_OVF];
      clr_v[`F_CAP2] = acc_ok & sel_dec[14] & armed_q[`F_CAP2];
      clr_v[`F_CMP2] = acc_ok & sel_dec[8] & armed_q[`F_CMP2];
   end

   wire [7:0]  flags_d = ((flags_q & ~clr_v) | set_v) & `FLAGS_MASK;

   wire        irq_any = (ctrl_a_q[`CA_CAP_IE] &
                          (flags_q[`F_CAP1] | flags_q[`F_CAP2])) |
                         (ctrl_a_q[`CA_CMP_IE] &
                          (flags_q[`F_CMP1] | flags_q[`F_CMP2])) |
                         (ctrl_a_q[`CA_OVF_IE] & flags_q[`F_OVF]);

   // apb slave: one wait state, answer registered
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready & ~pwrite) begin
            case (1'b1)
               sel_dec[0]:  prdata <= {24'h000000, ctrl_a_q};
               sel_dec[1]:  prdata <= {24'h000000, ctrl_b_q};
               sel_dec[2]:  prdata <= {24'h000000, flags_q};
               sel_dec[3]:  prdata <= {24'h000000, cap1_q[15:8]};
               sel_dec[4]:  prdata <= {24'h000000, cap1_q[7:0]};
               sel_dec[5]:  prdata <= {24'h000000, cmp1_q[15:8]};
               sel_dec[6]:  prdata <= {24'h000000, cmp1_q[7:0]};
               sel_dec[7]:  prdata <= {24'h000000, cmp2_q[15:8]};
               sel_dec[8]:  prdata <= {24'h000000, cmp2_q[7:0]};
               sel_dec[9]:  prdata <= {24'h000000, cnt_q[15:8]};
               sel_dec[10]: prdata <= {24'h000000, cnt_q[7:0]};
               sel_dec[11]: prdata <= {24'h000000, cnt_q[15:8]};
               sel_dec[12]: prdata <= {24'h000000, cnt_q[7:0]};
               sel_dec[13]: prdata <= {24'h000000, cap2_q[15:8]};
               sel_dec[14]: prdata <= {24'h000000, cap2_q[7:0]};
               default:     prdata <= 32'h00000000;
            endcase
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // control, compare values and flags
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_a_q    <= `CTRL_RST;
         ctrl_b_q    <= `CTRL_RST;
         flags_q     <= `FLAGS_RST;
         armed_q     <= `FLAGS_RST;
         cmp1_q      <= `CMP_RST;
         cmp2_q      <= `CMP_RST;
         cmp1_hold_q <= 1'b0;
         cmp2_hold_q <= 1'b0;
      end else begin
         if (wr_ok & sel_dec[0])
            ctrl_a_q <= wbyte;
         if (wr_ok & sel_dec[1])
            ctrl_b_q <= wbyte;
         // compare is held off between high and low byte writes
         if (wr_ok & sel_dec[5]) begin
            cmp1_q[15:8] <= wbyte;
            cmp1_hold_q  <= 1'b1;
         end
         if (wr_ok & sel_dec[6]) begin
            cmp1_q[7:0]  <= wbyte;
            cmp1_hold_q  <= 1'b0;
         end
         if (wr_ok & sel_dec[7]) begin
            cmp2_q[15:8] <= wbyte;
            cmp2_hold_q  <= 1'b1;
         end
         if (wr_ok & sel_dec[8]) begin
            cmp2_q[7:0]  <= wbyte;
            cmp2_hold_q  <= 1'b0;
         end
         flags_q <= flags_d;
         // status read arms the flags that were set; clearing disarms
         if (rd_ok & sel_dec[2])
            armed_q <= flags_q & ~clr_v;
         else
            armed_q <= armed_q & ~clr_v & flags_d;
      end
   end

   // counter, prescaler, captures, edge history
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q       <= `CNT_RST;
         presc_q     <= 3'h0;
         cap1_q      <= `CAP_RST;
         cap2_q      <= `CAP_RST;
         cap1_prev_q <= 1'b0;
         cap2_prev_q <= 1'b0;
         ext_prev_q  <= 1'b0;
      end else begin
         cap1_prev_q <= capture_one_input_pin;
         cap2_prev_q <= capture_two_input_pin;
         ext_prev_q  <= external_clock_pin;
         if (halt_mode | int_tick | (clk_sel == `CLK_EXT))
            presc_q <= 3'h0;
         else
            presc_q <= presc_q + 3'h1;
         if (cnt_wr)
            cnt_q <= `CNT_RST;
         else if (opm_on & cap1_ev)
            cnt_q <= `CNT_RST;
         else if (pwm_on & cmp2_hit)
            cnt_q <= `CNT_RST;
         else if (tick)
            cnt_q <= cnt_q + 16'h0001;
         if (cap1_ev) begin
            if (opm_on)
               cap1_q <= `CNT_OPM_CAP;
            else
               cap1_q <= cnt_q;
         end
         if (cap2_ev)
            cap2_q <= cnt_q;
      end
   end

   // pin levels: internal compare logic runs whatever the pin enables
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lvl1_q <= 1'b0;
         lvl2_q <= 1'b0;
      end else begin
         if (ctrl_a_q[`CA_FORCE1])
            lvl1_q <= ctrl_a_q[`CA_LVL1];
         else if (pwm_on & cmp2_hit)
            lvl1_q <= ctrl_a_q[`CA_LVL2];
         else if (opm_on & cap1_ev)
            lvl1_q <= ctrl_a_q[`CA_LVL2];
         else if (cmp1_hit)
            lvl1_q <= ctrl_a_q[`CA_LVL1];
         if (ctrl_a_q[`CA_FORCE2])
            lvl2_q <= ctrl_a_q[`CA_LVL2];
         else if (cmp2_hit & ~pwm_on & ~opm_on)
            lvl2_q <= ctrl_a_q[`CA_LVL2];
      end
   end

   // registered pin drivers and cpu signals
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         compare_one_output_pin <= 1'b0;
         compare_one_pin_enable <= 1'b0;
         compare_two_output_pin <= 1'b0;
         compare_two_pin_enable <= 1'b0;
         timer_irq              <= 1'b0;
         wake_from_wait         <= 1'b0;
      end else begin
         compare_one_output_pin <= lvl1_q;
         compare_one_pin_enable <= ctrl_b_q[`CB_PIN1_EN];
         compare_two_output_pin <= lvl2_q;
         compare_two_pin_enable <= ctrl_b_q[`CB_PIN2_EN];
         timer_irq              <= irq_any & ~cpu_irq_mask;
         // halt gives no wake; only wait does
         wake_from_wait         <= irq_any & ~cpu_irq_mask & wait_mode &
                                   ~halt_mode;
      end
   end

endmodule

// [testbench/timer16_checker.sv]
`timescale 1ns/1ps
`include "timer16_map.vh"
module timer16_checker (
   // clock and reset
   input wire        clk,
   input wire        sys_rst,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // cpu and pins
   input wire        cpu_irq_mask,
   input wire        wait_mode,
   input wire        halt_mode,
   input wire        timer_irq,
   input wire        wake_from_wait,
   input wire        compare_one_output_pin,
   input wire        compare_one_pin_enable,
   input wire        compare_two_output_pin,
   input wire        compare_two_pin_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire       take = psel && penable && pready && pwrite;
   reg  [7:0] ctrl_a_q;
   reg  [7:0] ctrl_b_q;
   reg  [1:0] since_q;
   // shadow of the control registers, cycles since last control write
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= 8'h00;
         since_q  <= 2'h3;
      end else if (take && (paddr == `A_CTRL_A || paddr == `A_CTRL_B)) begin
         since_q <= 2'h0;
         if (paddr == `A_CTRL_A)
            ctrl_a_q <= pwdata[7:0];
         else
            ctrl_b_q <= pwdata[7:0];
      end else if (since_q != 2'h3) begin
         since_q <= since_q + 2'h1;
      end
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   AST_READY_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error response with nonzero data");
   AST_FLAGS_LOW: assert property (pready && !pwrite && paddr == `A_FLAGS |->
      prdata[2:0] == 3'h0) else $error("reserved status bits not zero");
   AST_IRQ_MASK: assert property (timer_irq |-> !$past(cpu_irq_mask))
      else $error("request raised while masked");
   AST_WAKE: assert property (wake_from_wait |-> $past(wait_mode) && !$past(halt_mode))
      else $error("wake outside wait or during halt");
   AST_IRQ_OFF: assert property (since_q == 2'h3 && ctrl_a_q[7:5] == 3'h0 |-> !timer_irq)
      else $error("request with all enables clear");
   AST_PIN_EN: assert property (since_q[1] |->
      {compare_one_pin_enable, compare_two_pin_enable} == ctrl_b_q[7:6])
      else $error("pin enables differ from control b");
   AST_FORCE_ONE: assert property (since_q == 2'h3 && ctrl_a_q[3] && ctrl_b_q[7] &&
      ctrl_b_q[5:4] == 2'h0 |-> compare_one_output_pin == ctrl_a_q[0])
      else $error("forced level one not on pin one");
   AST_FORCE_TWO: assert property (since_q == 2'h3 && ctrl_a_q[4] && ctrl_b_q[6] |->
      compare_two_output_pin == ctrl_a_q[2]) else $error("forced level two not on pin two");
endmodule
bind timer16_control_status_irq timer16_checker chk_i (.clk, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_irq_mask, .wait_mode,
   .halt_mode, .timer_irq, .wake_from_wait, .compare_one_output_pin, .compare_one_pin_enable,
   .compare_two_output_pin, .compare_two_pin_enable);

// [testbench/timer16_control_status_irq_tb_top.sv]
`timescale 1ns/1ps
`include "timer16_map.vh"
module timer16_control_status_irq_tb_top;
   typedef struct packed {
      logic       w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] x;
      logic       e;
   } row_t;
   logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        cpu_irq_mask = 1'b1, wait_mode = 1'b0, halt_mode = 1'b0;
   logic        cap1 = 1'b0, cap2 = 1'b0, ext = 1'b0;
   wire  [31:0] prdata;
   wire         pready, pslverr, timer_irq, wake_from_wait, pin1, pin1_en, pin2, pin2_en;
   int          mismatches = 0, compares = 0;
   int          dv [0:2] = '{4, 2, 8};
   logic [31:0] r;
   logic        e, ok;
   logic [7:0]  n;
   row_t        rows [0:14] = '{{1'b0, `A_CTRL_A, 8'h00, 8'h00, 1'b0},
      {1'b0, `A_CTRL_B, 8'h00, 8'h00, 1'b0}, {1'b1, `A_CTRL_B, 8'h0C, 8'h00, 1'b0},
      {1'b0, `A_CTRL_B, 8'h00, 8'h0C, 1'b0}, {1'b1, `A_CTRL_A, 8'hA5, 8'h00, 1'b0},
      {1'b0, `A_CTRL_A, 8'h00, 8'hA5, 1'b0}, {1'b1, `A_CTRL_A, 8'h00, 8'h00, 1'b0},
      {1'b1, `A_CNT_LO, 8'h00, 8'h00, 1'b0}, {1'b0, `A_CNT_HI, 8'h00, 8'hFF, 1'b0},
      {1'b0, `A_CNT_LO, 8'h00, 8'hFC, 1'b0}, {1'b1, `A_FLAGS, 8'hFF, 8'h00, 1'b0},
      {1'b0, `A_FLAGS, 8'h00, 8'h00, 1'b0}, {1'b1, `A_CAP1_HI, 8'h55, 8'h00, 1'b0},
      {1'b0, `A_CAP1_HI, 8'h00, 8'h00, 1'b0}, {1'b0, 8'h3C, 8'h00, 8'h00, 1'b1}};
   timer16_control_status_irq uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode),
      .halt_mode(halt_mode), .timer_irq(timer_irq), .wake_from_wait(wake_from_wait),
      .capture_one_input_pin(cap1), .capture_two_input_pin(cap2), .external_clock_pin(ext),
      .compare_one_output_pin(pin1), .compare_one_pin_enable(pin1_en),
      .compare_two_output_pin(pin2), .compare_two_pin_enable(pin2_en));
   task results;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // look at the answer mid-cycle, where it is settled
      @(negedge clk);
      while (pready !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      if (k >= 20)
         chk(k, 0);
      q = prdata;
      err = pslverr;
      @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task ext_pulses(input int cnt);
      repeat (cnt) begin
         @(posedge clk);
         ext <= 1'b1;
         repeat (3) @(posedge clk);
         ext <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task wait_clk(input int c);
      repeat (c) @(posedge clk);
   endtask
   initial forever #12.5 clk = ~clk;
   // bench needs about 480 cycles
   initial begin
      #125000;
      mismatches++;
      results;
   end
   initial begin
      wait_clk(20);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, {24'h0, rows[i].d}, r, e);
         if (!rows[i].w)
            chk(r, {24'h0, rows[i].x});
         chk(e, rows[i].e);
      end
      wr(`A_CTRL_B, 8'h0D);
      ext_pulses(3);
      rd(`A_CNT_LO, 32'hFF);
      wr(`A_CTRL_B, 8'h0C);
      ext_pulses(1);
      rd(`A_CNT_LO, 32'h00);
      rd(`A_FLAGS, 32'h20);
      wr(`A_CTRL_A, 8'h20);
      wait_clk(4);
      chk(timer_irq, 0);
      cpu_irq_mask <= 1'b0;
      wait_clk(4);
      chk(timer_irq, 1);
      wait_mode <= 1'b1;
      wait_clk(3);
      chk(wake_from_wait, 1);
      halt_mode <= 1'b1;
      wait_clk(3);
      chk(wake_from_wait, 0);
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
      rd(`A_ALT_LO, 32'h00);
      rd(`A_FLAGS, 32'h20);
      rd(`A_CNT_LO, 32'h00);
      rd(`A_FLAGS, 32'h00);
      wr(`A_CNT_LO, 8'h00);
      wr(`A_CTRL_A, 8'h82);
      cap1 <= 1'b1;
      cap2 <= 1'b1;
      wait_clk(3);
      rd(`A_FLAGS, 32'h80);
      cap1 <= 1'b0;
      cap2 <= 1'b0;
      wait_clk(3);
      rd(`A_FLAGS, 32'h90);
      chk(timer_irq, 1);
      rd(`A_CAP1_HI, 32'hFF);
      rd(`A_CAP1_LO, 32'hFC);
      rd(`A_CAP2_LO, 32'hFC);
      rd(`A_FLAGS, 32'h00);
      wr(`A_CTRL_B, 8'hCC);
      wr(`A_CTRL_A, 8'h1D);
      wait_clk(4);
      chk({pin1, pin2}, 2'b11);
      chk({pin1_en, pin2_en}, 2'b11);
      wr(`A_CTRL_A, 8'h18);
      wait_clk(4);
      chk({pin1, pin2}, 2'b00);
      wr(`A_CMP1_HI, 8'hFF);
      wr(`A_CMP1_LO, 8'hFE);
      wr(`A_CTRL_A, 8'h01);
      wr(`A_CTRL_B, 8'h84);
      wait_clk(16);
      chk(pin1, 1);
      apb(1'b0, `A_FLAGS, 32'h0, r, e);
      chk(r & 32'h40, 32'h40);
      for (int k = 0; k < 3; k++) begin
         wr(`A_CTRL_B, {4'h0, k[1:0], 2'h0});
         wr(`A_CNT_LO, 8'h00);
         wait_clk(48);
         wr(`A_CTRL_B, 8'h0C);
         apb(1'b0, `A_CNT_LO, 32'h0, r, e);
         n = r[7:0] - 8'hFC;
         ok = (n >= 44 / dv[k]) && (n <= 60 / dv[k] + 1);
         chk(ok, 1);
      end
      // one-pulse: capture edge reloads counter, level two on pin one
      wr(`A_CTRL_A, 8'h02);
      wr(`A_CTRL_B, 8'hAC);
      cap1 <= 1'b1;
      wait_clk(4);
      chk(pin1, 0);
      rd(`A_CAP1_LO, 32'hFD);
      rd(`A_CNT_LO, 32'hFC);
      cap1 <= 1'b0;
      // second reset in mid-run
      sys_rst <= 1'b1;
      wait_clk(2);
      sys_rst <= 1'b0;
      rd(`A_CTRL_B, 32'h00);
      rd(`A_CAP1_LO, 32'h00);
      chk(pin1, 0);
      results;
   end
endmodule
